/* File: logic/capture_trigger_consts.vh */
/*
 Register offsets, field positions, reset values and timing counts
 for the camera trigger input and delay block.
 Assumes bit 0 is the most significant bit of each 32-bit word.
*/
`ifndef CAPTURE_TRIGGER_CONSTS_VH
`define CAPTURE_TRIGGER_CONSTS_VH

`define ADDR_DELAY_CAPS 32'hf0f00534
`define ADDR_DELAY_CTRL 32'hf0f00834
`define ADDR_LINE_CFG_1 32'hf1000300
`define ADDR_LINE_CFG_2 32'hf1000304
`define ADDR_FINE_DELAY 32'hf1000400

// positions in hardware (lsb=0) numbering: field bit n -> 31-n
`define POS_PRESENCE 31
`define POS_ABS 30
`define POS_ONE_PUSH 28
`define POS_READOUT 27
`define POS_ON_OFF_CAP 26
`define POS_AUTO 25
`define POS_MANUAL 24
`define POS_POLARITY 24
`define POS_ON_OFF 25
`define POS_FUNC_LSB 16
`define POS_LEVEL 0
`define POS_MIN_LSB 12
`define POS_MAX_LSB 0

`define FUNC_OFF 5'h00
`define FUNC_TRIGGER 5'h02
`define FUNC_SEQ_STEP 5'h06
`define FUNC_SEQ_RESTART 5'h07

`define RST_FUNC_1 5'h02
`define RST_FUNC_2 5'h00
`define RST_VALUE 12'h000

`define CLK_HZ 20000000
`define MICROSECOND_NS 1000
`define CLK_PERIOD_NS 50
`define CYCLES_PER_US (`MICROSECOND_NS / `CLK_PERIOD_NS)

`endif

/* File: logic/delay_counter.v */
/*
 Down counter that holds a trigger edge back by a number of ticks.
 Assumes tick is a one-cycle enable and start is a one-cycle pulse.
*/
`timescale 1ns/100ps
module delay_counter #(
  parameter WIDTH = 21
) (
  input wire clk,
  input wire srst,
  input wire start,
  input wire tick,
  input wire [WIDTH-1:0] count,
  output reg fire_ff
);
  reg [WIDTH-1:0] remain_ff;
  reg busy_ff;

  // a new edge while busy restarts the wait
  always @(posedge clk) begin
    if (srst) begin
      remain_ff <= {WIDTH{1'b0}};
      busy_ff <= 1'b0;
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= 1'b0;
      if (start) begin
        if (count == {WIDTH{1'b0}}) begin
          fire_ff <= 1'b1;
          busy_ff <= 1'b0;
        end else begin
          remain_ff <= count;
          busy_ff <= 1'b1;
        end
      end else if (busy_ff && tick) begin
        if (remain_ff == {{(WIDTH-1){1'b0}}, 1'b1}) begin
          fire_ff <= 1'b1;
          busy_ff <= 1'b0;
        end
        remain_ff <= remain_ff - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // delay_counter

/* File: logic/capture_trigger_input.v */
/*
 Two opto-isolated camera inputs: sync, polarity, routing, AND of
 triggers, edge detect and two capture delay mechanisms.
 Assumes a simple word register port from the camera controller and a
 20 MHz clock; the absolute delay value arrives in microseconds.
*/
// Function
// - isolator inverts each input; internal level is the connector complement.
// - all trigger-routed inputs are ANDed after polarity adjustment.
// - combined trigger starts capture only in external trigger mode.
// - top bit of each input word reads one, writes ignored.
// - polarity bit 0 leaves signal uninverted, 1 inverts it.
// - five-bit function field routes input; input one defaults to trigger.
// - level bit returns isolator output negated again, true connector level.
// - an open input reads zero in its level bit.
// - second input word sits one word above, same layout and behaviour.
// - capability word reports 12-bit minimum and maximum delay fields.
// - capability flags for abs, one-push, readout, on/off, auto, manual; one-push and auto read zero.
// - control word holds 12-bit delay value in time base units.
// - absolute-control bit selects the absolute value register instead.
// - on/off bit enables delay; reads return the current state.
// - control word top bit reads one while delay is available.
// - advanced word: enable bit six and 21-bit microsecond delay.
// - switching delay on also enables edge external trigger mode.
// - delay acts only in edge external trigger mode, else bypassed.
`timescale 1ns/100ps
`include "capture_trigger_consts.vh"
module capture_trigger_input #(
  parameter TIMEBASE_US = 1,
  parameter [11:0] DELAY_MIN = 12'h000,
  parameter [11:0] DELAY_MAX = 12'hfff
) (
  input wire clk,
  input wire srst,
  input wire [1:0] opto_out,
  input wire ext_trigger_mode,
  input wire edge_mode_in,
  input wire [20:0] abs_delay_us,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_ff,
  output reg capture_start_ff,
  output reg trigger_level_ff,
  output reg seq_advance_ff,
  output reg seq_restart_ff,
  output reg edge_mode_set_ff
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  reg [1:0] polarity_ff;
  reg [9:0] func_ff;
  reg std_on_ff;
  reg std_abs_ff;
  reg [11:0] std_value_ff;
  reg fine_on_ff;
  reg [20:0] fine_us_ff;

  // ------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------
  reg [1:0] s1_ff;
  reg [1:0] s2_ff;
  reg [1:0] s3_ff;
  reg [1:0] level_ff;
  wire [1:0] active;
  wire [1:0] is_trig;
  wire [1:0] is_step;
  wire [1:0] is_rst;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_line
      // a change is taken once stages two and three agree
      always @(posedge clk) begin
        if (srst) begin
          s1_ff[i] <= 1'b1;
          s2_ff[i] <= 1'b1;
          s3_ff[i] <= 1'b1;
          level_ff[i] <= 1'b0;
        end else begin
          s1_ff[i] <= opto_out[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i]) begin
            level_ff[i] <= ~s3_ff[i];
          end
        end
      end
      // polarity 0 passes the isolator signal, i.e. low active
      assign active[i] = polarity_ff[i] ? level_ff[i] : ~level_ff[i];
      assign is_trig[i] = (func_ff[i*5 +: 5] == `FUNC_TRIGGER);
      assign is_step[i] = (func_ff[i*5 +: 5] == `FUNC_SEQ_STEP);
      assign is_rst[i] = (func_ff[i*5 +: 5] == `FUNC_SEQ_RESTART);
    end
  endgenerate

  // with no trigger input assigned the combined trigger stays low
  wire any_trig = |is_trig;
  wire trig_and = any_trig & (&(active | ~is_trig));
  reg trig_d_ff;
  reg [1:0] step_d_ff;
  reg [1:0] rst_d_ff;
  wire trig_edge = trig_and & ~trig_d_ff;

  // ------------------------------------------------------------
  // delays
  // ------------------------------------------------------------
  localparam integer US_LAST = `CYCLES_PER_US - 1;
  reg [4:0] us_div_ff;
  wire us_tick = (us_div_ff == US_LAST[4:0]);
  wire delay_on = std_on_ff | fine_on_ff;
  wire edge_mode = edge_mode_in | edge_mode_set_ff;
  wire use_delay = delay_on & edge_mode;
  // fine delay wins; standard uses the absolute value when selected
  wire [31:0] std_prod = std_value_ff * TIMEBASE_US;
  wire [20:0] std_us = std_abs_ff ? abs_delay_us : std_prod[20:0];
  wire [20:0] delay_us = fine_on_ff ? fine_us_ff : std_us;
  wire delayed_fire;
  wire gated_edge = trig_edge & ext_trigger_mode;
  wire delay_start = gated_edge & use_delay;

  delay_counter #(.WIDTH(21)) u_delay (
    .clk(clk),
    .srst(srst),
    .start(delay_start),
    .tick(us_tick),
    .count(delay_us),
    .fire_ff(delayed_fire)
  );

  always @(posedge clk) begin
    if (srst) begin
      us_div_ff <= 5'h00;
      // idle combined trigger is high with the default setup; avoids a false edge
      trig_d_ff <= 1'b1;
      step_d_ff <= 2'h0;
      rst_d_ff <= 2'h0;
      capture_start_ff <= 1'b0;
      trigger_level_ff <= 1'b0;
      seq_advance_ff <= 1'b0;
      seq_restart_ff <= 1'b0;
    end else begin
      // restart the divider on a new wait so the first tick is a full microsecond
      us_div_ff <= (us_tick | delay_start) ? 5'h00 : us_div_ff + 5'h01;
      trig_d_ff <= trig_and;
      step_d_ff <= active & is_step;
      rst_d_ff <= active & is_rst;
      trigger_level_ff <= trig_and & ext_trigger_mode;
      capture_start_ff <= use_delay ? delayed_fire : gated_edge;
      seq_advance_ff <= |(active & is_step & ~step_d_ff);
      seq_restart_ff <= |(active & is_rst & ~rst_d_ff);
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      polarity_ff <= 2'h0;
      func_ff <= {`RST_FUNC_2, `RST_FUNC_1};
      std_on_ff <= 1'b0;
      std_abs_ff <= 1'b0;
      std_value_ff <= `RST_VALUE;
      fine_on_ff <= 1'b0;
      fine_us_ff <= 21'h000000;
      edge_mode_set_ff <= 1'b0;
    end else if (reg_wr) begin
      // presence and reserved bits are simply not stored
      case (reg_addr)
        `ADDR_LINE_CFG_1: begin
          polarity_ff[0] <= reg_wdata[`POS_POLARITY];
          func_ff[4:0] <= reg_wdata[`POS_FUNC_LSB +: 5];
        end
        `ADDR_LINE_CFG_2: begin
          polarity_ff[1] <= reg_wdata[`POS_POLARITY];
          func_ff[9:5] <= reg_wdata[`POS_FUNC_LSB +: 5];
        end
        `ADDR_DELAY_CTRL: begin
          std_abs_ff <= reg_wdata[`POS_ABS];
          std_on_ff <= reg_wdata[`POS_ON_OFF];
          std_value_ff <= reg_wdata[11:0];
          if (reg_wdata[`POS_ON_OFF]) begin
            edge_mode_set_ff <= 1'b1;
          end
        end
        `ADDR_FINE_DELAY: begin
          fine_on_ff <= reg_wdata[`POS_ON_OFF];
          fine_us_ff <= reg_wdata[20:0];
          if (reg_wdata[`POS_ON_OFF]) begin
            edge_mode_set_ff <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h00000000;
    case (reg_addr)
      `ADDR_LINE_CFG_1: begin
        nxt_rdata[`POS_PRESENCE] = 1'b1;
        nxt_rdata[`POS_POLARITY] = polarity_ff[0];
        nxt_rdata[`POS_FUNC_LSB +: 5] = func_ff[4:0];
        nxt_rdata[`POS_LEVEL] = level_ff[0];
      end
      `ADDR_LINE_CFG_2: begin
        nxt_rdata[`POS_PRESENCE] = 1'b1;
        nxt_rdata[`POS_POLARITY] = polarity_ff[1];
        nxt_rdata[`POS_FUNC_LSB +: 5] = func_ff[9:5];
        nxt_rdata[`POS_LEVEL] = level_ff[1];
      end
      `ADDR_DELAY_CAPS: begin
        nxt_rdata[`POS_PRESENCE] = 1'b1;
        nxt_rdata[`POS_ABS] = 1'b1;
        nxt_rdata[`POS_READOUT] = 1'b1;
        nxt_rdata[`POS_ON_OFF_CAP] = 1'b1;
        nxt_rdata[`POS_MANUAL] = 1'b1;
        nxt_rdata[`POS_MIN_LSB +: 12] = DELAY_MIN;
        nxt_rdata[`POS_MAX_LSB +: 12] = DELAY_MAX;
      end
      `ADDR_DELAY_CTRL: begin
        nxt_rdata[`POS_PRESENCE] = 1'b1;
        nxt_rdata[`POS_ABS] = std_abs_ff;
        nxt_rdata[`POS_ON_OFF] = std_on_ff;
        nxt_rdata[11:0] = std_value_ff;
      end
      `ADDR_FINE_DELAY: begin
        nxt_rdata[`POS_PRESENCE] = 1'b1;
        nxt_rdata[`POS_ON_OFF] = fine_on_ff;
        nxt_rdata[20:0] = fine_us_ff;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      reg_rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end
endmodule // capture_trigger_input

/* File: verification/trigger_source.sv */
/*
 Model of the external trigger sources on the two isolated camera inputs.
 Assumes the bench sets the connector levels and which inputs are plugged.
*/
`timescale 1ns/100ps
module trigger_source (
  input wire [1:0] level,
  input wire [1:0] plugged,
  output wire [1:0] opto_out
);
  // an open input sits low at the connector, so the isolator output stays high
  assign opto_out = ~(level & plugged);
endmodule // trigger_source

/* File: verification/capture_trigger_chk.sv */
/*
 Concurrent checks on the ports of the camera trigger input block.
 Assumes one clock and the synchronous active high reset.
*/
`timescale 1ns/100ps
`include "capture_trigger_consts.vh"
module capture_trigger_chk #(
  parameter [11:0] DELAY_MIN = 12'h000,
  parameter [11:0] DELAY_MAX = 12'hfff
) (
  input wire clk,
  input wire srst,
  input wire ext_trigger_mode,
  input wire edge_mode_in,
  input wire reg_rd,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_rdata_ff,
  input wire capture_start_ff,
  input wire trigger_level_ff,
  input wire seq_advance_ff,
  input wire seq_restart_ff,
  input wire edge_mode_set_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // register reads
  // ----------------------------------------
  sequence s_read(a);
    reg_rd && reg_addr == a;
  endsequence
  a_caps_word: assert property (s_read(`ADDR_DELAY_CAPS) |=>
    reg_rdata_ff == {8'hcd, DELAY_MIN, DELAY_MAX}) else $error("caps word wrong");
  a_ctrl_top: assert property (s_read(`ADDR_DELAY_CTRL) |=>
    reg_rdata_ff[31] && reg_rdata_ff[29:26] == 4'h0) else $error("ctrl word wrong");
  a_input_word: assert property (reg_rd && (reg_addr == `ADDR_LINE_CFG_1
    || reg_addr == `ADDR_LINE_CFG_2) |=> reg_rdata_ff[31] && reg_rdata_ff[30:25] == 6'h00
    && reg_rdata_ff[23:21] == 3'h0 && reg_rdata_ff[15:1] == 15'h0000)
    else $error("input word wrong");
  a_unmapped_zero: assert property (s_read(32'hf1000308) |=> reg_rdata_ff == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data moved without read");
  // ----------------------------------------
  // trigger path
  // ----------------------------------------
  sequence s_level_up;
    $rose(trigger_level_ff) && $past(ext_trigger_mode, 2) && !edge_mode_in && !edge_mode_set_ff;
  endsequence
  a_level_gate: assert property (!ext_trigger_mode [*3] |-> !trigger_level_ff)
    else $error("trigger level outside external mode");
  a_no_delay: assert property (s_level_up |-> capture_start_ff)
    else $error("undelayed capture missing");
  a_cap_pulse: assert property (capture_start_ff |=> !capture_start_ff)
    else $error("capture pulse too long");
  a_seq_pulse: assert property (seq_advance_ff || seq_restart_ff |=>
    !seq_advance_ff && !seq_restart_ff) else $error("sequence pulse too long");
  a_edge_sticky: assert property (!$fell(edge_mode_set_ff))
    else $error("edge mode cleared");
endmodule // capture_trigger_chk

bind capture_trigger_input capture_trigger_chk #(.DELAY_MIN(DELAY_MIN), .DELAY_MAX(DELAY_MAX))
  capture_trigger_chk_i (.clk(clk), .srst(srst), .ext_trigger_mode(ext_trigger_mode),
  .edge_mode_in(edge_mode_in), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata_ff(reg_rdata_ff), .capture_start_ff(capture_start_ff),
  .trigger_level_ff(trigger_level_ff), .seq_advance_ff(seq_advance_ff),
  .seq_restart_ff(seq_restart_ff), .edge_mode_set_ff(edge_mode_set_ff));

/* File: verification/capture_trigger_input_tb.sv */
/*
 Self-checking bench for the camera trigger input block.
 Assumes the trigger_source model in front of the isolated inputs.
*/
`timescale 1ns/100ps
`include "capture_trigger_consts.vh"
module capture_trigger_input_tb;
  logic clk = 0;
  logic srst = 1;
  logic ext = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [1:0] lvl = 0;
  logic [1:0] plug = 0;
  logic [1:0] opto;
  logic [20:0] abs_us = 0;
  logic [31:0] addr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic cap, trig, adv, rs, eset;
  int fail_count = 0;
  int compares = 0;
  int adv_n = 0;
  int rs_n = 0;
  int base, n;
  always #25 clk = ~clk;
  always @(negedge clk) begin
    if (adv === 1'b1) adv_n <= adv_n + 1;
    if (rs === 1'b1) rs_n <= rs_n + 1;
  end
  trigger_source trigger_source_i (.level(lvl), .plugged(plug), .opto_out(opto));
  capture_trigger_input capture_trigger_input_i (.clk(clk), .srst(srst), .opto_out(opto),
    .ext_trigger_mode(ext), .edge_mode_in(1'b0), .abs_delay_us(abs_us), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_ff(rdata),
    .capture_start_ff(cap), .trigger_level_ff(trig), .seq_advance_ff(adv),
    .seq_restart_ff(rs), .edge_mode_set_ff(eset));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chkr(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("mismatch at %0t: latency %0d", $time, got);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1;
    addr = a;
    wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_rd = 1;
    addr = a;
    @(negedge clk);
    reg_rd = 0;
    chk(rdata, e);
  endtask
  // cycles from connector edge to capture; 300 means none came
  task go(input logic [1:0] l, output int k);
    @(negedge clk);
    lvl = l;
    k = 0;
    while (cap !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    repeat (8) @(negedge clk);
    lvl = 0;
    repeat (8) @(negedge clk);
  endtask
  task settle;
    repeat (6) @(negedge clk);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #1000000;
    fail_count++;
    close_out;
  end
  initial begin
    repeat (8) @(negedge clk);
    srst = 0;
    rd(`ADDR_LINE_CFG_1, 32'h80020000);
    rd(`ADDR_LINE_CFG_2, 32'h80000000);
    rd(`ADDR_DELAY_CAPS, 32'hcd000fff);
    rd(`ADDR_DELAY_CTRL, 32'h80000000);
    rd(`ADDR_FINE_DELAY, 32'h80000000);
    rd(32'hf1000308, 32'h0);
    wr(`ADDR_LINE_CFG_2, 32'h7f07ffff);
    rd(`ADDR_LINE_CFG_2, 32'h81070000);
    $display("test registers done");
    plug = 2'b11;
    lvl = 2'b01;
    settle;
    rd(`ADDR_LINE_CFG_1, 32'h80020001);
    ext = 1;
    settle;
    chk(trig, 0);
    lvl = 0;
    settle;
    chk(trig, 1);
    wr(`ADDR_LINE_CFG_1, 32'h01020000);
    wr(`ADDR_LINE_CFG_2, 32'h01020000);
    lvl = 2'b01;
    settle;
    chk(trig, 0);
    lvl = 2'b11;
    settle;
    chk(trig, 1);
    ext = 0;
    settle;
    chk(trig, 0);
    lvl = 0;
    settle;
    ext = 1;
    go(2'b11, base);
    chkr(base, 4, 7);
    go(2'b01, n);
    chkr(n, 300, 300);
    $display("test trigger done");
    for (int f = 6; f < 8; f++) begin
      wr(`ADDR_LINE_CFG_2, 32'h01000000 | (f << 16));
      lvl = 2'b10;
      settle;
      lvl = 0;
      settle;
    end
    chk(adv_n, 1);
    chk(rs_n, 1);
    wr(`ADDR_LINE_CFG_2, 32'h01000000);
    $display("test sequence done");
    wr(`ADDR_FINE_DELAY, 32'h02000003);
    rd(`ADDR_FINE_DELAY, 32'h82000003);
    chk(eset, 1);
    go(2'b01, n);
    chkr(n, base + 58, base + 64);
    wr(`ADDR_FINE_DELAY, 32'h0);
    wr(`ADDR_DELAY_CTRL, 32'h02000005);
    rd(`ADDR_DELAY_CTRL, 32'h82000005);
    go(2'b01, n);
    chkr(n, base + 98, base + 104);
    abs_us = 2;
    wr(`ADDR_DELAY_CTRL, 32'h42000005);
    go(2'b01, n);
    chkr(n, base + 38, base + 44);
    $display("test delay done");
    close_out;
  end
endmodule // capture_trigger_input_tb
